// >>> shared/scbio_pkg.sv
// Purpose: Constants for the single channel buffered I/O section.
// Assumes: One channel, 18-bit words, 15-bit memory addresses.
// Notes: Register indexes are word indexes; byte address is index times four.
package scbio_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 15;
    localparam int DIR_BIT = 17;
    localparam int MON_BIT = 16;
    localparam logic [5:0] CHAN_NUM = 6'h02;
    localparam logic [11:0] CODE_EF = 12'hA0B;
    localparam logic [11:0] CODE_OUT = 12'hA0A;
    localparam logic [11:0] CODE_IN = 12'hA09;
    localparam logic [1:0] T_EF = 2'h0;
    localparam logic [1:0] T_OUT = 2'h1;
    localparam logic [1:0] T_IN = 2'h2;
    localparam logic [1:0] T_EI = 2'h3;
    localparam logic [7:0] IDX_EF_TERM = 8'h14;
    localparam logic [7:0] IDX_EF_CUR = 8'h15;
    localparam logic [7:0] IDX_OUT_TERM = 8'h24;
    localparam logic [7:0] IDX_OUT_CUR = 8'h25;
    localparam logic [7:0] IDX_IN_TERM = 8'h34;
    localparam logic [7:0] IDX_IN_CUR = 8'h35;
    localparam logic [7:0] IDX_LIM_TERM = 8'h40;
    localparam logic [7:0] IDX_LIM_INIT = 8'h41;
    localparam logic [7:0] IDX_CMD = 8'h42;
    localparam logic [7:0] IDX_STATUS = 8'h43;
    localparam logic [14:0] EI_ENTRY = 15'h0040;
    localparam logic [14:0] ONE_ADDR = 15'h0001;
    localparam int ST_ACT = 0;
    localparam int ST_MON = 3;
    localparam int ST_EI = 6;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_MOVE = 2'h1,
        S_DRIVE = 2'h3,
        S_HOLD = 2'h2
    } scbio_state_t;
endpackage : scbio_pkg

// >>> verilog/scbio_core.sv
// Purpose: Buffered I/O section for one channel in single channel mode.
// Assumes: Memory answers a read with data valid in the cycle after mem_rd.
// Notes: Peripheral lines are asynchronous and pass two flip-flops first.
`timescale 1ns/1ns
`default_nettype none
module scbio_core
    import scbio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_function_req,
    input wire logic out_req,
    input wire logic input_word_req,
    input wire logic ext_int_req,
    output logic ext_function_ack,
    output logic out_ack,
    output logic input_word_ack,
    output logic ext_int_ack,
    input wire logic [17:0] data_in,
    output logic [17:0] data_out,
    output logic [14:0] mem_addr,
    output logic mem_rd,
    output logic mem_we,
    output logic [17:0] mem_wdata,
    input wire logic [17:0] mem_rdata,
    output logic [2:0] monitor_irq,
    output logic ext_int_flag
);
    logic [3:0] req_m, req_s;
    logic [17:0] din_m, din_s;
    logic [17:0] term [3];
    logic [17:0] cur [3];
    logic [2:0] active;
    logic [17:0] lim_term, lim_init;
    logic [3:0] ack_vec;
    logic [1:0] cur_t;
    logic last, last_mon;
    scbio_state_t state;
    logic wr_hit, start_hit, st_clr;
    logic [7:0] idx;
    logic [1:0] ct;
    logic [3:0] want;
    logic [1:0] gsel;
    logic gval, eq;
    logic [17:0] next_cur;
    logic done_ev;

    // Two stages on every line from the cable; only the second is read.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_m <= 4'h0;
            req_s <= 4'h0;
            din_m <= 18'h00000;
            din_s <= 18'h00000;
        end else begin
            req_m <= {ext_int_req, input_word_req, out_req, ext_function_req};
            req_s <= req_m;
            din_m <= data_in;
            din_s <= din_m;
        end
    end

    assign idx = wb_adr_i[9:2];
    // Writes land on the edge where ack is high; ack alternates while a request is held, so a held request writes every other cycle.
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign st_clr = wr_hit && idx == IDX_STATUS;

    always_comb begin
        ct = T_EF;
        if (wb_dat_i[17:6] == CODE_OUT) begin
            ct = T_OUT;
        end else if (wb_dat_i[17:6] == CODE_IN) begin
            ct = T_IN;
        end
    end
    assign start_hit = wr_hit && idx == IDX_CMD && wb_dat_i[5:0] == CHAN_NUM
        && (wb_dat_i[17:6] == CODE_EF || wb_dat_i[17:6] == CODE_OUT
        || wb_dat_i[17:6] == CODE_IN);

    // Bus slave: one wait cycle, ack for one cycle, unmapped reads as zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            lim_term <= 18'h00000;
            lim_init <= 18'h00000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wr_hit && idx == IDX_LIM_TERM) begin
                lim_term <= wb_dat_i[17:0];
            end
            if (wr_hit && idx == IDX_LIM_INIT) begin
                lim_init <= wb_dat_i[17:0];
            end
            unique case (idx)
                IDX_EF_TERM: wb_dat_o <= {14'h0000, term[T_EF]};
                IDX_EF_CUR: wb_dat_o <= {14'h0000, cur[T_EF]};
                IDX_OUT_TERM: wb_dat_o <= {14'h0000, term[T_OUT]};
                IDX_OUT_CUR: wb_dat_o <= {14'h0000, cur[T_OUT]};
                IDX_IN_TERM: wb_dat_o <= {14'h0000, term[T_IN]};
                IDX_IN_CUR: wb_dat_o <= {14'h0000, cur[T_IN]};
                IDX_LIM_TERM: wb_dat_o <= {14'h0000, lim_term};
                IDX_LIM_INIT: wb_dat_o <= {14'h0000, lim_init};
                IDX_STATUS: wb_dat_o <= {25'h0000000, ext_int_flag, monitor_irq, active};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Fixed order: function, output, input, then external interrupt.
    always_comb begin
        want = {req_s[3], req_s[2:0] & active};
        gval = |want;
        gsel = T_EI;
        if (want[0]) begin
            gsel = T_EF;
        end else if (want[1]) begin
            gsel = T_OUT;
        end else if (want[2]) begin
            gsel = T_IN;
        end
    end
    assign eq = gsel != T_EI && term[gsel] == cur[gsel];
    // Only the fifteen address bits step; the option bits ride along.
    assign next_cur = {cur[gsel][17:15], cur[gsel][DIR_BIT]
        ? cur[gsel][14:0] - ONE_ADDR : cur[gsel][14:0] + ONE_ADDR};
    assign done_ev = state == S_HOLD && ack_vec != 4'h0 && !req_s[cur_t];

    // Control words, active flags and monitor flags.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 3'h0;
            monitor_irq <= 3'h0;
            ext_int_flag <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                term[i] <= 18'h00000;
                cur[i] <= 18'h00000;
            end
        end else begin
            if (st_clr) begin
                monitor_irq <= monitor_irq & ~wb_dat_i[ST_MON+2:ST_MON];
                ext_int_flag <= ext_int_flag & ~wb_dat_i[ST_EI];
            end
            if (state == S_IDLE && gval && gsel != T_EI) begin
                if (eq) begin
                    active[gsel] <= 1'b0;
                end
                if (eq && gsel != T_IN) begin
                    if (cur[gsel][MON_BIT]) begin
                        monitor_irq[gsel] <= 1'b1;
                    end
                end else begin
                    cur[gsel] <= next_cur;
                end
            end
            if (done_ev && cur_t == T_EI) begin
                ext_int_flag <= 1'b1;
            end
            if (done_ev && last && last_mon) begin
                monitor_irq[T_IN] <= 1'b1;
            end
            if (start_hit) begin
                active[ct] <= 1'b1;
                term[ct] <= lim_term;
                cur[ct] <= lim_init;
            end
        end
    end

    // Transfer sequence: issue memory access, drive or store, then handshake.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cur_t <= T_EF;
            last <= 1'b0;
            last_mon <= 1'b0;
            mem_addr <= 15'h0000;
            mem_rd <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= 18'h00000;
            data_out <= 18'h00000;
            ack_vec <= 4'h0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (gval && !(eq && gsel != T_IN)) begin
                        cur_t <= gsel;
                        last <= eq;
                        last_mon <= cur[gsel][MON_BIT];
                        state <= S_MOVE;
                        if (gsel == T_EI) begin
                            mem_addr <= EI_ENTRY + ONE_ADDR;
                            mem_wdata <= din_s;
                            mem_we <= 1'b1;
                        end else if (gsel == T_IN) begin
                            mem_addr <= cur[gsel][14:0];
                            mem_wdata <= din_s;
                            mem_we <= 1'b1;
                        end else begin
                            mem_addr <= cur[gsel][14:0];
                            mem_rd <= 1'b1;
                        end
                    end
                end
                S_MOVE: begin
                    mem_rd <= 1'b0;
                    mem_we <= 1'b0;
                    state <= S_DRIVE;
                end
                S_DRIVE: begin
                    if (cur_t == T_EF || cur_t == T_OUT) begin
                        data_out <= mem_rdata;
                    end
                    state <= S_HOLD;
                end
                S_HOLD: begin
                    // Acknowledge a cycle after the word is on the lines.
                    if (ack_vec == 4'h0) begin
                        ack_vec[cur_t] <= 1'b1;
                    end else if (!req_s[cur_t]) begin
                        ack_vec <= 4'h0;
                        last <= 1'b0;
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end
    assign ext_function_ack = ack_vec[0];
    assign out_ack = ack_vec[1];
    assign input_word_ack = ack_vec[2];
    assign ext_int_ack = ack_vec[3];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence seq_store;
        mem_we ##1 !mem_we ##1 state == S_HOLD;
    endsequence

    sequence seq_fetch;
        mem_rd ##1 !mem_rd ##1 state == S_HOLD;
    endsequence

    chk_ack_after_data: assert property (
        $rose(ack_vec[0] | ack_vec[1]) |-> $past(state) == S_HOLD && $stable(data_out))
        else $error("Acknowledge rose without data settled.");
    chk_inactive_ignored: assert property (
        state == S_IDLE && !active[T_IN] && !want[0] && !want[1] && !req_s[3]
        |=> state == S_IDLE)
        else $error("Inactive input request was served.");
    chk_out_terminate: assert property (
        state == S_IDLE && gval && eq && gsel != T_IN
        |=> !active[$past(gsel)] && state == S_IDLE && !mem_rd)
        else $error("Output termination moved a word.");
    chk_in_last_word: assert property (
        state == S_IDLE && gval && eq && gsel == T_IN
        |=> !active[T_IN] ##0 seq_store)
        else $error("Final input word not stored.");
    chk_step_dir: assert property (
        state == S_IDLE && gval && gsel != T_EI && !(eq && gsel != T_IN) && !start_hit
        |=> cur[cur_t] == $past(next_cur))
        else $error("Current word stepped wrongly.");
    chk_start_load: assert property (
        start_hit |=> active[$past(ct)] && cur[$past(ct)] == $past(lim_init))
        else $error("Buffer start did not load words.");
    chk_ef_first: assert property (
        state == S_IDLE && want[0] |=> !mem_we)
        else $error("Function request lost priority.");
    chk_ei_store: assert property (
        state == S_IDLE && gval && gsel == T_EI
        |=> mem_we && mem_addr == EI_ENTRY + ONE_ADDR)
        else $error("Interrupt code stored at wrong place.");
    chk_mon_raise: assert property (
        state == S_IDLE && gval && eq && gsel == T_OUT && cur[T_OUT][MON_BIT]
        |=> monitor_irq[T_OUT])
        else $error("Monitor flag not raised.");
    chk_out_fetch: assert property (
        state == S_IDLE && gval && gsel != T_IN && gsel != T_EI && !eq
        |=> seq_fetch)
        else $error("Output word not fetched before handshake.");
    chk_ack_held: assert property (
        state == S_HOLD && ack_vec != 4'h0 && req_s[cur_t]
        |=> state == S_HOLD && ack_vec == $past(ack_vec))
        else $error("Acknowledge dropped while request still high.");
    chk_ack_onehot: assert property (
        ack_vec != 4'h0 |-> $onehot(ack_vec))
        else $error("More than one acknowledge line high.");
    chk_in_store_addr: assert property (
        state == S_IDLE && gval && gsel == T_IN
        |=> mem_we && mem_addr == $past(cur[T_IN][14:0]) && mem_wdata == $past(din_s))
        else $error("Input word stored at wrong place.");
    chk_mon_input: assert property (
        done_ev && last && last_mon |=> monitor_irq[T_IN])
        else $error("Input monitor flag not raised.");
    chk_ei_flag_set: assert property (
        done_ev && cur_t == T_EI |=> ext_int_flag)
        else $error("Interrupt flag not raised.");
endmodule : scbio_core
`default_nettype wire

// >>> sim/scbio_far.sv
// Purpose: Memory model on the far side of the buffered I/O section.
// Assumes: A read returns data in the cycle after mem_rd.
// Notes: Idle read data flips every cycle so stale words never look valid.
`timescale 1ns/1ns
`default_nettype none
module scbio_far (
    input wire logic ref_clk,
    input wire logic [14:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_we,
    input wire logic [17:0] mem_wdata,
    output logic [17:0] mem_rdata
);
    logic [17:0] mem [32768];
    initial mem_rdata = 18'h15555;
    always @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : scbio_far
`default_nettype wire

// >>> sim/scbio_core_test.sv
// Purpose: Self-checking bench for the single channel buffered I/O block.
// Assumes: Bench plays the peripheral; scbio_far plays memory.
// Notes: Expected words and addresses come from a small model of the buffer.
`timescale 1ns/1ns
`default_nettype none
module scbio_core_test
    import scbio_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, wack, eif, mrd, mwe;
    logic [9:0] adr = '0;
    logic [31:0] dat = '0, rdo, seed = 32'h5757;
    logic [3:0] sel = 4'hF, req = '0, ack;
    logic [17:0] din = '0, dout, wdat, rdat;
    logic [14:0] maddr;
    logic [2:0] mon;
    logic [17:0] code [3] = '{18'h282C2, 18'h28282, 18'h28242};
    int err_total = 0, checked = 0;
    always #20 ref_clk = ~ref_clk;
    scbio_core scbio_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdo), .wb_ack_o(wack), .ext_function_req(req[0]), .out_req(req[1]),
        .input_word_req(req[2]), .ext_int_req(req[3]), .ext_function_ack(ack[0]),
        .out_ack(ack[1]), .input_word_ack(ack[2]), .ext_int_ack(ack[3]), .data_in(din),
        .data_out(dout), .mem_addr(maddr), .mem_rd(mrd), .mem_we(mwe), .mem_wdata(wdat),
        .mem_rdata(rdat), .monitor_irq(mon), .ext_int_flag(eif));
    scbio_far scbio_far_inst (.ref_clk(ref_clk), .mem_addr(maddr), .mem_rd(mrd),
        .mem_we(mwe), .mem_wdata(wdat), .mem_rdata(rdat));
    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    function automatic logic [17:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[17:0];
    endfunction : xs
    task automatic wb(input logic w, input logic [7:0] i, input logic [17:0] d,
        output logic [31:0] q);
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        dat <= {14'h0, d};
        for (k = 0; k < 20 && wack !== 1'b1; k++) @(posedge ref_clk);
        q = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 20) begin
            cmp("wb_ack", 1, 0);
            print_verdict();
        end
    endtask : wb
    // The peripheral holds its request until acknowledged or 40 cycles pass, then drops it.
    task automatic serve(input int t, input logic [17:0] d, output logic ok,
        output logic [17:0] got);
        int k;
        @(posedge ref_clk);
        din <= d;
        req[t] <= 1'b1;
        for (k = 0; k < 40 && ack[t] !== 1'b1; k++) @(posedge ref_clk);
        ok = (k < 40);
        got = dout;
        req[t] <= 1'b0;
        for (k = 0; k < 20 && ack[t] !== 1'b0; k++) @(posedge ref_clk);
        if (k == 20) begin
            cmp("ack_drop", 0, 1);
            print_verdict();
        end
    endtask : serve
    task automatic run(input int t, input logic [17:0] term, input logic [17:0] init);
        logic [31:0] q;
        logic [17:0] cur, w, got;
        logic ok, eq;
        int k;
        wb(1'b1, IDX_LIM_TERM, term, q);
        wb(1'b1, IDX_LIM_INIT, init, q);
        wb(1'b1, IDX_CMD, code[t], q);
        cur = init;
        for (k = 0; k < 8; k++) begin
            eq = (cur === term);
            w = xs();
            scbio_far_inst.mem[cur[14:0]] = (t == 2) ? ~w : w;
            serve(t, w, ok, got);
            if (t != 2 && eq) begin
                cmp("late_ack", 0, ok);
                break;
            end
            cmp("ack", 1, ok);
            cmp("word", w, (t == 2) ? scbio_far_inst.mem[cur[14:0]] : got);
            cur = {cur[17:15], cur[17] ? cur[14:0] - 15'h1 : cur[14:0] + 15'h1};
            if (t == 2 && eq) break;
        end
        wb(1'b0, 8'h15 + 8'h10 * t[7:0], 18'h0, q);
        cmp("cur_word", {14'h0, cur}, q);
        wb(1'b0, IDX_STATUS, 18'h0, q);
        cmp("status", term[16] ? (32'h8 << t) : 32'h0, q);
        cmp("irq_pin", term[16] ? (32'h1 << t) : 32'h0, {29'h0, mon});
        wb(1'b1, IDX_STATUS, 18'h78, q);
    endtask : run
    initial begin
        logic [31:0] q;
        logic [17:0] w, got, init;
        logic ok;
        int k;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        cmp("irq_reset", 0, {29'h0, mon});
        wb(1'b0, IDX_STATUS, 18'h0, q);
        cmp("status_reset", 0, q);
        serve(1, 18'h0, ok, got);
        cmp("idle_ack", 0, ok);
        run(0, 18'h01003, 18'h01000);
        run(1, 18'h30202, 18'h30205);
        run(2, 18'h00302, 18'h00300);
        run(2, 18'h3000E, 18'h30010);
        // Random spans include zero length, the awkward output case.
        for (k = 0; k < 3; k++) begin
            w = xs();
            init = {w[17:16], 6'h0, w[9:0]};
            run(k, {init[17:15], init[17] ? init[14:0] - w[11:10] : init[14:0] + w[11:10]},
                init);
        end
        w = xs();
        serve(3, w, ok, got);
        cmp("int_ack", 1, ok);
        cmp("int_code", w, scbio_far_inst.mem[EI_ENTRY + ONE_ADDR]);
        repeat (2) @(posedge ref_clk);
        cmp("int_flag", 1, eif);
        // Leave a monitor flag and an active input buffer pending, then reset mid-run.
        wb(1'b1, IDX_LIM_TERM, 18'h10100, q);
        wb(1'b1, IDX_LIM_INIT, 18'h10100, q);
        wb(1'b1, IDX_CMD, code[1], q);
        serve(1, 18'h0, ok, got);
        cmp("empty_ack", 0, ok);
        wb(1'b1, IDX_CMD, code[2] ^ 18'h1, q);
        wb(1'b0, IDX_STATUS, 18'h0, q);
        cmp("status_badchan", 32'h50, q);
        wb(1'b1, IDX_CMD, code[2], q);
        wb(1'b0, IDX_STATUS, 18'h0, q);
        cmp("status_pre_reset", 32'h54, q);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b0, IDX_STATUS, 18'h0, q);
        cmp("status_mid_reset", 0, q);
        cmp("irq_mid_reset", 0, {29'h0, mon});
        wb(1'b0, 8'h7F, 18'h0, q);
        cmp("unmapped", 0, q);
        print_verdict();
    end
endmodule : scbio_core_test
`default_nettype wire
